// ==== logic/cfss_defs.svh ====
`ifndef CFSS_DEFS_SVH
`define CFSS_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CFSS_CLK_NS 8
// unit of the smoothing setting, 0.1 ms, in ns
`define CFSS_TICK_NS 100000
`define CFSS_TICK_CYC (`CFSS_TICK_NS / `CFSS_CLK_NS)

// ----------------------------------------------------------------
// setting limits and switching wait (wait counted in half ticks)
// ----------------------------------------------------------------
`define CFSS_SMOOTH_MAX 14'h2710
`define CFSS_SPD_TC_MAX 14'h0280
`define CFSS_WAIT_KNEE 14'h0064
`define CFSS_WAIT_ADD 16'h0005
`define CFSS_WAIT_MUL 32'h00000015
`define CFSS_WAIT_DIV 32'h0000000A
`define CFSS_WAIT_RND 32'h00000009

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CFSS_OFS_CTRL 8'h00
`define CFSS_OFS_SMOOTH 8'h04
`define CFSS_OFS_STATUS 8'h08
`define CFSS_OFS_SELSTAT 8'h0C
`define CFSS_OFS_RESPTC 8'h10
`define CFSS_OFS_PRESET 8'h20
`define CFSS_OFS_PRESET_END 8'h3C

// ----------------------------------------------------------------
// control register fields and the status pending bit
// ----------------------------------------------------------------
`define CFSS_CTRL_MODE 1:0
`define CFSS_CTRL_TWODOF 2
`define CFSS_CTRL_SRC 4:3
`define CFSS_CTRL_DIRM 5
`define CFSS_STAT_PEND 16

`endif

// ==== logic/cfss_fir.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cfss_defs.svh"

module cfss_fir (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic tick,
   input wire logic [13:0] taps,
   input wire logic inPulse,
   input wire logic inDir,
   output logic outPulse,
   output logic outDir
);

   // ----------------------------------------------------------------
   // history of net pulse counts per tick, one word per tick
   // ----------------------------------------------------------------
   logic signed [15:0] hist [0:16383];
   cfss_pkg::cfss_fir_state_t q;
   cfss_pkg::cfss_fir_state_t d;
   logic signed [15:0] n;
   logic signed [15:0] old;
   logic signed [28:0] accIn;
   logic signed [28:0] tapsS;

   // count this tick, slide the window, then meter pulses out of acc
   always_comb begin
      d = q;
      d.outPulse = 1'b0;
      tapsS = $signed({15'h0000, taps});
      n = q.cnt;
      if (inPulse) begin
         n = inDir ? q.cnt - 16'sh0001 : q.cnt + 16'sh0001;
      end
      old = (taps == 14'h0000) ? 16'sh0000 : hist[q.ptr - taps];
      accIn = q.acc;
      if (tick) begin
         d.cnt = 16'sh0000;
         d.ptr = q.ptr + 14'h0001;
         if (taps != 14'h0000) begin
            d.sum = q.sum + 28'(n) - 28'(old); // window of taps ticks
            accIn = q.acc + 29'(d.sum);
         end
      end else begin
         d.cnt = n;
      end
      if (taps == 14'h0000) begin
         // zero setting: the command passes unsmoothed
         d.outPulse = inPulse;
         d.outDir = inDir;
         d.acc = q.acc;
      end else if (accIn >= tapsS) begin
         d.outPulse = 1'b1;
         d.outDir = 1'b0;
         d.acc = accIn - tapsS;
      end else if (accIn <= -tapsS) begin
         d.outPulse = 1'b1;
         d.outDir = 1'b1;
         d.acc = accIn + tapsS;
      end else begin
         d.acc = accIn;
      end
   end

   // the history keeps being written in bypass so it stays current
   always_ff @(posedge clk_sys) begin
      if (!reset && ce && tick) begin
         hist[q.ptr] <= n;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   assign outPulse = q.outPulse;
   assign outDir = q.outDir;

endmodule : cfss_fir
`default_nettype wire

// ==== logic/cfss_pkg.sv ====
package cfss_pkg;

   typedef enum logic [1:0] {
      CFSS_MODE_POS = 2'b00,
      CFSS_MODE_SPD = 2'b01,
      CFSS_MODE_FULL = 2'b10,
      CFSS_MODE_RSV = 2'b11
   } cfss_mode_t;

   typedef enum logic [1:0] {
      CFSS_SRC_ANALOG = 2'b00,
      CFSS_SRC_INT4 = 2'b01,
      CFSS_SRC_INT3A = 2'b10,
      CFSS_SRC_INT8 = 2'b11
   } cfss_src_t;

   typedef enum logic {
      CFSS_SW_IDLE = 1'b0,
      CFSS_SW_WAIT = 1'b1
   } cfss_sw_t;

   typedef struct packed {
      logic [5:0] sync1;
      logic [5:0] sync2;
      logic pulsePrev;
      logic [12:0] halfCnt;
      logic halfPhase;
      cfss_mode_t mode;
      logic twoDof;
      cfss_src_t src;
      logic dirMethod;
      logic [13:0] setReq;
      logic [13:0] setAct;
      logic [13:0] firTaps;
      cfss_sw_t sw;
      logic [15:0] waitCnt;
      logic [15:0] waitTarget;
      logic [7:0][15:0] preset;
      logic aValid;
      logic aWrite;
      logic [7:0] aAddr;
      logic [31:0] hrdata;
      logic hreadyout;
      logic [13:0] respTc;
      logic [15:0] speedCmd;
      logic speedNeg;
      logic useAnalog;
      logic [2:0] speedIndex;
   } cfss_state_t;

   typedef struct packed {
      logic signed [15:0] cnt;
      logic signed [27:0] sum;
      logic signed [28:0] acc;
      logic [13:0] ptr;
      logic outPulse;
      logic outDir;
   } cfss_fir_state_t;

endpackage : cfss_pkg

// ==== logic/cfss_top.sv ====
// Operation
// - smoothing setting 0..10000, default zero
// - average travel time equals setting ticks
// - switching wait from setting, two formulas
// - new setting waits for pulse-free wait
// - pulse during wait suspends the change
// - speed mode, two-dof off: setting ignored
// - speed mode, two-dof on: clamp 640
// - position/full-closed: setting is fir length
// - source select 0..3, default analog
// - sources 1,2 binary a/b; 2 uses analog
// - source 3: c selects speeds five-eight
// - direction method bit, default zero
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "cfss_defs.svh"

module cfss_top #(
   parameter int TICK_CYC = `CFSS_TICK_CYC
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cmdPulseIn,
   input wire logic cmdDirIn,
   input wire logic presetSpeedSelectA,
   input wire logic presetSpeedSelectB,
   input wire logic presetSpeedSelectC,
   input wire logic speedDirIn,
   output logic cmdPulseOut,
   output logic cmdDirOut,
   output logic [13:0] respFilterTc,
   output logic [15:0] speedCmd,
   output logic speedNeg,
   output logic useAnalog,
   output logic [2:0] speedIndex
);

   localparam logic [12:0] HALF_LAST = 13'(TICK_CYC / 2 - 1);

   cfss_pkg::cfss_state_t q;
   cfss_pkg::cfss_state_t d;
   logic halfTick;
   logic tick;
   logic pulseEdge;
   logic wrData;
   logic [1:0] selCode;
   logic [15:0] presetVal;
   logic hrespQ;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------

   // wait in half ticks, rounded up; 0.25 ms below the knee, x1.05 above
   function automatic logic [15:0] waitFor(input logic [13:0] s);
      logic [31:0] w;
      w = (`CFSS_WAIT_MUL * {18'h00000, s} + `CFSS_WAIT_RND) / `CFSS_WAIT_DIV;
      if (s < `CFSS_WAIT_KNEE) begin
         waitFor = {1'b0, s, 1'b0} + `CFSS_WAIT_ADD;
      end else begin
         waitFor = w[15:0];
      end
   endfunction : waitFor

   function automatic logic [13:0] clampSet(input logic [31:0] v);
      clampSet = (v > {18'h00000, `CFSS_SMOOTH_MAX}) ? `CFSS_SMOOTH_MAX : v[13:0];
   endfunction : clampSet

   function automatic logic [31:0] readReg(input cfss_pkg::cfss_state_t s,
                                           input logic [7:0] a);
      readReg = 32'h00000000;
      case (a)
         `CFSS_OFS_CTRL: begin
            readReg[`CFSS_CTRL_MODE] = s.mode;
            readReg[`CFSS_CTRL_TWODOF] = s.twoDof;
            readReg[`CFSS_CTRL_SRC] = s.src;
            readReg[`CFSS_CTRL_DIRM] = s.dirMethod;
         end
         `CFSS_OFS_SMOOTH: readReg[13:0] = s.setReq;
         `CFSS_OFS_STATUS: begin
            readReg[13:0] = s.setAct;
            readReg[`CFSS_STAT_PEND] = (s.sw == cfss_pkg::CFSS_SW_WAIT);
         end
         `CFSS_OFS_SELSTAT: readReg[3:0] = {s.useAnalog, s.speedIndex};
         `CFSS_OFS_RESPTC: readReg[13:0] = s.respTc;
         default: begin
            if (a >= `CFSS_OFS_PRESET && a <= `CFSS_OFS_PRESET_END) begin
               readReg[15:0] = s.preset[a[4:2]];
            end
         end
      endcase
   endfunction : readReg

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      // pins pass two flops before anything looks at them
      d.sync1 = {speedDirIn, presetSpeedSelectC, presetSpeedSelectB,
                 presetSpeedSelectA, cmdDirIn, cmdPulseIn};
      d.sync2 = q.sync1;
      d.pulsePrev = q.sync2[0];
      pulseEdge = q.sync2[0] & ~q.pulsePrev;

      // half-tick strobe; tick is every second one
      halfTick = (q.halfCnt == HALF_LAST);
      tick = halfTick & q.halfPhase;
      d.halfCnt = halfTick ? 13'h0000 : q.halfCnt + 13'h0001;
      d.halfPhase = q.halfPhase ^ halfTick;

      // ahb-lite: zero-wait slave, read data registered in address phase
      d.aValid = hsel & hready & htrans[1];
      d.aWrite = hwrite;
      d.aAddr = haddr[7:0];
      if (hsel & hready & htrans[1] & ~hwrite) begin
         d.hrdata = readReg(q, haddr[7:0]);
      end
      wrData = q.aValid & q.aWrite;

      // switching wait; any command pulse restarts the pulse-free count
      if (q.sw == cfss_pkg::CFSS_SW_WAIT) begin
         if (pulseEdge) begin
            d.waitCnt = 16'h0000;
         end else if (halfTick) begin
            d.waitCnt = q.waitCnt + 16'h0001;
            if (q.waitCnt + 16'h0001 >= q.waitTarget) begin
               d.setAct = q.setReq;
               d.sw = cfss_pkg::CFSS_SW_IDLE;
            end
         end
      end

      if (wrData) begin
         case (q.aAddr)
            `CFSS_OFS_CTRL: begin
               d.mode = cfss_pkg::cfss_mode_t'(hwdata[`CFSS_CTRL_MODE]);
               d.twoDof = hwdata[`CFSS_CTRL_TWODOF];
               d.src = cfss_pkg::cfss_src_t'(hwdata[`CFSS_CTRL_SRC]);
               d.dirMethod = hwdata[`CFSS_CTRL_DIRM];
            end
            `CFSS_OFS_SMOOTH: begin
               // never applied at once; the old setting keeps running
               d.setReq = clampSet(hwdata);
               d.waitCnt = 16'h0000;
               // wait long enough to drain the larger of the two windows
               // d.setAct, not q: an old wait may end on this very edge
               d.waitTarget = (clampSet(hwdata) > d.setAct) ?
                              waitFor(clampSet(hwdata)) : waitFor(d.setAct);
               d.sw = (clampSet(hwdata) == d.setAct) ?
                      cfss_pkg::CFSS_SW_IDLE : cfss_pkg::CFSS_SW_WAIT;
            end
            default: begin
               if (q.aAddr >= `CFSS_OFS_PRESET && q.aAddr <= `CFSS_OFS_PRESET_END) begin
                  d.preset[q.aAddr[4:2]] = hwdata[15:0];
               end
            end
         endcase
      end

      // how the active setting is used in each control mode
      case (q.mode)
         cfss_pkg::CFSS_MODE_POS,
         cfss_pkg::CFSS_MODE_FULL: begin
            d.firTaps = q.setAct;
            d.respTc = q.setAct;
         end
         cfss_pkg::CFSS_MODE_SPD: begin
            d.firTaps = 14'h0000;
            if (!q.twoDof) begin
               d.respTc = 14'h0000;
            end else if (q.setAct > `CFSS_SPD_TC_MAX) begin
               d.respTc = `CFSS_SPD_TC_MAX;
            end else begin
               d.respTc = q.setAct;
            end
         end
         default: begin
            d.firTaps = 14'h0000;
            d.respTc = 14'h0000;
         end
      endcase

      // speed source; select inputs are {c,b,a} = sync2[4:2]
      selCode = q.sync2[3:2]; // a is the low bit
      d.useAnalog = 1'b0;
      d.speedIndex = {1'b0, selCode};
      case (q.src)
         cfss_pkg::CFSS_SRC_ANALOG: d.useAnalog = 1'b1;
         cfss_pkg::CFSS_SRC_INT4: d.speedIndex = {1'b0, selCode};
         cfss_pkg::CFSS_SRC_INT3A: d.useAnalog = (selCode == 2'b11);
         cfss_pkg::CFSS_SRC_INT8: d.speedIndex = {q.sync2[4], selCode};
         default: d.useAnalog = 1'b1;
      endcase
      presetVal = q.preset[d.speedIndex];
      if (d.useAnalog) begin
         d.speedCmd = 16'h0000;
         d.speedNeg = q.dirMethod & q.sync2[5];
      end else if (!q.dirMethod) begin
         d.speedCmd = presetVal;
         d.speedNeg = presetVal[15];
      end else begin
         d.speedCmd = presetVal[15] ? 16'h0000 - presetVal : presetVal;
         d.speedNeg = q.sync2[5]; // pin off means positive
      end
   end

   // ----------------------------------------------------------------
   // state register; ce low freezes everything
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         q <= '0;
         q.hreadyout <= 1'b1;
         hrespQ <= 1'b0;
      end else if (ce) begin
         q <= d;
         hrespQ <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // smoothing filter on the position command
   // ----------------------------------------------------------------
   cfss_fir u_fir (
      .clk_sys(clk_sys),
      .reset(reset),
      .ce(ce),
      .tick(tick),
      .taps(q.firTaps),
      .inPulse(pulseEdge),
      .inDir(q.sync2[1]),
      .outPulse(cmdPulseOut),
      .outDir(cmdDirOut)
   );

   assign hrdata = q.hrdata;
   assign hreadyout = q.hreadyout;
   assign hresp = hrespQ;
   assign respFilterTc = q.respTc;
   assign speedCmd = q.speedCmd;
   assign speedNeg = q.speedNeg;
   assign useAnalog = q.useAnalog;
   assign speedIndex = q.speedIndex;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);

   AST_SET_RANGE: assert property (q.setReq <= `CFSS_SMOOTH_MAX && q.setAct <= `CFSS_SMOOTH_MAX)
      else $error("smoothing setting out of range");
   AST_WAIT_SMALL: assert property (q.sw == cfss_pkg::CFSS_SW_WAIT && q.setReq < `CFSS_WAIT_KNEE
      && q.setAct < `CFSS_WAIT_KNEE |-> q.waitTarget == waitFor((q.setReq > q.setAct) ?
      q.setReq : q.setAct))
      else $error("switching wait target wrong");
   AST_APPLY_LATE: assert property ($changed(q.setAct) |-> $past(q.sw) == cfss_pkg::CFSS_SW_WAIT
      && $past(q.waitCnt) + 16'h0001 >= $past(q.waitTarget) && !$past(pulseEdge))
      else $error("setting applied before the wait ran out");
   AST_PULSE_RESTART: assert property (ce && pulseEdge && q.sw == cfss_pkg::CFSS_SW_WAIT
      && !wrData |=> q.waitCnt == 16'h0000 && $stable(q.setAct))
      else $error("pulse did not suspend the change");
   AST_SPD_IGNORE: assert property (ce && q.mode == cfss_pkg::CFSS_MODE_SPD && !q.twoDof
      |=> respFilterTc == 14'h0000 && q.firTaps == 14'h0000)
      else $error("setting used with two-dof off");
   AST_SPD_CLAMP: assert property (ce && q.mode == cfss_pkg::CFSS_MODE_SPD && q.twoDof
      |=> respFilterTc == (($past(q.setAct) > `CFSS_SPD_TC_MAX) ? `CFSS_SPD_TC_MAX
      : $past(q.setAct)))
      else $error("response time constant not clamped");
   AST_FIR_TAPS: assert property (ce && (q.mode == cfss_pkg::CFSS_MODE_POS
      || q.mode == cfss_pkg::CFSS_MODE_FULL) |=> q.firTaps == $past(q.setAct))
      else $error("fir length differs from active setting");
   AST_SRC_ANALOG: assert property (ce && q.src == cfss_pkg::CFSS_SRC_ANALOG |=> useAnalog)
      else $error("analog source not selected");
   AST_SRC_MIX: assert property (ce && q.src == cfss_pkg::CFSS_SRC_INT3A
      |=> useAnalog == ($past(q.sync2[3:2]) == 2'b11))
      else $error("mixed source decode wrong");
   AST_SRC_EIGHT: assert property (ce && q.src == cfss_pkg::CFSS_SRC_INT8
      |=> !useAnalog && speedIndex == $past(q.sync2[4:2]))
      else $error("eight speed decode wrong");
   AST_DIR_PIN: assert property (ce && q.dirMethod |=> speedNeg == $past(q.sync2[5]))
      else $error("direction not taken from pin");
   AST_DIR_SIGN: assert property (ce && !q.dirMethod && !d.useAnalog
      |=> speedNeg == speedCmd[15])
      else $error("direction not taken from preset sign");

   COV_APPLY: cover property ($changed(q.setAct));
   COV_SUSPEND: cover property (pulseEdge && q.sw == cfss_pkg::CFSS_SW_WAIT);
   COV_MIX_ANALOG: cover property (q.src == cfss_pkg::CFSS_SRC_INT3A && useAnalog);
   COV_FIR_OUT: cover property (cmdPulseOut && q.firTaps != 14'h0000);

endmodule : cfss_top
`default_nettype wire

// ==== tb/cfss_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none

// host side: command pulses and select contacts, changed just after an edge
module cfss_host_model (
   input wire logic clk_sys,
   output logic cmdPulseIn,
   output logic cmdDirIn,
   output logic presetSpeedSelectA,
   output logic presetSpeedSelectB,
   output logic presetSpeedSelectC,
   output logic speedDirIn
);
   // idle: no pulse, all contacts off
   initial begin
      {cmdPulseIn, cmdDirIn, speedDirIn} = 3'h0;
      {presetSpeedSelectA, presetSpeedSelectB, presetSpeedSelectC} = 3'h0;
   end

   // pulse high two cycles, then low for gap cycles; gap sets how prompt the host is
   task automatic sendPulses(input int n, input int gap, input logic dir);
      for (int k = 0; k < n; k++) begin
         cmdDirIn <= dir;
         cmdPulseIn <= 1'h1;
         repeat (2) @(posedge clk_sys);
         cmdPulseIn <= 1'h0;
         repeat (gap) @(posedge clk_sys);
      end
   endtask : sendPulses

   // one select contact per step; the direction pin flips on the same edge as a
   task automatic pickSpeed(input logic [2:0] code, input logic dir);
      speedDirIn <= dir;
      presetSpeedSelectA <= code[0];
      repeat (2) @(posedge clk_sys);
      presetSpeedSelectB <= code[1];
      repeat (2) @(posedge clk_sys);
      presetSpeedSelectC <= code[2];
      @(posedge clk_sys);
   endtask : pickSpeed
endmodule : cfss_host_model

`default_nettype wire

// ==== tb/command_fir_and_speed_select_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "cfss_defs.svh"

module command_fir_and_speed_select_bench;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   localparam int TICK = 20;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hready, hreadyout, hresp, cmdPulseIn, cmdDirIn, speedDirIn;
   logic selA, selB, selC, cmdPulseOut, cmdDirOut, speedNeg, useAnalog;
   logic pinPrev = 1'h0;
   logic [13:0] respFilterTc;
   logic [15:0] speedCmd;
   logic [2:0] speedIndex;
   int mismatches = 0;
   int compares = 0;
   int actSet = 0;
   longint cyc = 0, inSum = 0, outCnt = 0, outSum = 0;

   always #4 clk_sys = ~clk_sys;
   assign hready = hreadyout;

   cfss_top #(.TICK_CYC(TICK)) i_cfss_top (
      .clk_sys(clk_sys), .reset(reset), .ce(1'h1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmdPulseIn(cmdPulseIn),
      .cmdDirIn(cmdDirIn), .presetSpeedSelectA(selA), .presetSpeedSelectB(selB),
      .presetSpeedSelectC(selC), .speedDirIn(speedDirIn), .cmdPulseOut(cmdPulseOut),
      .cmdDirOut(cmdDirOut), .respFilterTc(respFilterTc), .speedCmd(speedCmd),
      .speedNeg(speedNeg), .useAnalog(useAnalog), .speedIndex(speedIndex));

   cfss_host_model i_cfss_host_model (
      .clk_sys(clk_sys), .cmdPulseIn(cmdPulseIn), .cmdDirIn(cmdDirIn),
      .presetSpeedSelectA(selA), .presetSpeedSelectB(selB),
      .presetSpeedSelectC(selC), .speedDirIn(speedDirIn));

   // pulse times on both sides of the filter, for the mean delay
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      pinPrev <= cmdPulseIn;
      if (cmdPulseIn === 1'h1 && pinPrev === 1'h0) inSum <= inSum + cyc;
      if (cmdPulseOut === 1'h1) begin
         outCnt <= outCnt + 1;
         outSum <= outSum + cyc;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : check

   // bounded wait for hready at a rising edge; a hang ends the run
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hready !== 1'h1 && n < 50);
      if (hready !== 1'h1) begin
         mismatches++;
         $display("unexpected at %0t: bus hang", $time);
         conclude();
      end
   endtask : waitReady

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      waitReady();
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'h1, a, d, x);
   endtask : wr

   task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] x;
      bus(1'h0, a, 32'h0, x);
      check(x, exp, what);
      check(32'(hresp), 32'h0, "hresp");
   endtask : rdChk

   // switching wait in cycles, half ticks of TICK/2 cycles
   function automatic int waitFor(input int s);
      return (s < 100) ? (2 * s + 5) * TICK / 2 : ((21 * s + 9) / 10) * TICK / 2;
   endfunction : waitFor

   function automatic logic [15:0] presetOf(input int i);
      logic [15:0] v;
      v = 16'((i + 1) * 256);
      return (i % 2 == 1) ? 16'(-v) : v;
   endfunction : presetOf

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic resetValues();
      rdChk(`CFSS_OFS_CTRL, 32'h0, "ctrl");
      rdChk(`CFSS_OFS_SMOOTH, 32'h0, "smooth");
      rdChk(`CFSS_OFS_SELSTAT, 32'h8, "selstat");
      rdChk(8'h18, 32'h0, "unmapped");
      wr(`CFSS_OFS_SMOOTH, 32'h3000);
      rdChk(`CFSS_OFS_SMOOTH, 32'h2710, "clamp");
      wr(`CFSS_OFS_SMOOTH, 32'h0);
      rdChk(`CFSS_OFS_STATUS, 32'h0, "cancel");
   endtask : resetValues

   // host idle while the new value waits out its pulse-free time
   task automatic applySetting(input int s);
      int w;
      w = waitFor(s > actSet ? s : actSet);
      wr(`CFSS_OFS_SMOOTH, 32'(s));
      repeat (w - 20) @(posedge clk_sys);
      rdChk(`CFSS_OFS_STATUS, 32'h00010000 | 32'(actSet), "pending");
      repeat (45) @(posedge clk_sys);
      rdChk(`CFSS_OFS_STATUS, 32'(s), "applied");
      actSet = s;
   endtask : applySetting

   // burst of six pulses in one direction: all come out, centred on half the length
   task automatic runFir(input logic dir);
      longint s0, o0, t0;
      int d;
      s0 = inSum;
      o0 = outCnt;
      t0 = outSum;
      i_cfss_host_model.sendPulses(6, 4, dir);
      repeat (60 + actSet * TICK * 2) @(posedge clk_sys);
      check(32'(outCnt - o0), 32'h6, "pulse count");
      check(32'(cmdDirOut), 32'(dir), "direction");
      d = int'((outSum - t0 - (inSum - s0)) / 6);
      check(32'(d > actSet * TICK / 2 - 40 && d < actSet * TICK / 2 + 45), 32'h1, "delay");
   endtask : runFir

   // pulses closer than the wait keep the change back
   task automatic suspendChange();
      wr(`CFSS_OFS_SMOOTH, 32'h8);
      i_cfss_host_model.sendPulses(5, 100, 1'h0);
      rdChk(`CFSS_OFS_STATUS, 32'h00010004, "held");
      repeat (waitFor(8) + 25) @(posedge clk_sys);
      rdChk(`CFSS_OFS_STATUS, 32'h8, "released");
      actSet = 8;
   endtask : suspendChange

   task automatic speedMode();
      wr(`CFSS_OFS_CTRL, 32'h05);
      repeat (3) @(posedge clk_sys);
      rdChk(`CFSS_OFS_RESPTC, 32'h64, "below clamp");
      applySetting(700);
      rdChk(`CFSS_OFS_RESPTC, 32'h280, "clamped");
      check(32'(respFilterTc), 32'h280, "tc port");
      wr(`CFSS_OFS_CTRL, 32'h01);
      repeat (3) @(posedge clk_sys);
      rdChk(`CFSS_OFS_RESPTC, 32'h0, "ignored");
   endtask : speedMode

   // every source, both direction methods, all eight contact codes
   task automatic selectSpeeds();
      logic [15:0] p, e;
      logic an;
      logic [2:0] ix;
      for (int i = 0; i < 8; i++) wr(`CFSS_OFS_PRESET + 8'(4 * i), 32'(presetOf(i)));
      for (int m = 0; m < 8; m++) begin
         wr(`CFSS_OFS_CTRL, 32'(1 + 8 * (m % 4) + 32 * (m / 4)));
         for (int c = 0; c < 8; c++) begin
            i_cfss_host_model.pickSpeed(3'(c), c[1]);
            repeat (8) @(posedge clk_sys);
            ix = 3'(c) & ((m % 4 == 3) ? 3'h7 : 3'h3);
            an = (m % 4 == 0) || (m % 4 == 2 && c % 4 == 3);
            p = presetOf(ix);
            e = (m >= 4 && p[15]) ? 16'(-p) : p;
            check(32'(useAnalog), 32'(an), "analog");
            if (an) check(32'(speedCmd), 32'h0, "analog speed");
            else begin
               check(32'(speedIndex), 32'(ix), "index");
               check(32'(speedCmd), 32'(e), "speed");
               check(32'(speedNeg), 32'(m >= 4 ? c[1] : p[15]), "sign");
            end
         end
      end
   endtask : selectSpeeds

   // main sequence
   initial begin
      repeat (2) @(posedge clk_sys);
      reset <= 1'h0;
      @(posedge clk_sys);
      resetValues();
      runFir(1'h1);
      applySetting(4);
      // full-closed mode smooths exactly like position mode
      wr(`CFSS_OFS_CTRL, 32'h02);
      runFir(1'h0);
      suspendChange();
      applySetting(100);
      speedMode();
      selectSpeeds();
      conclude();
   end
endmodule : command_fir_and_speed_select_bench

`default_nettype wire
